// File: include/drt_pkg.sv
// Package: register map, field positions, reset values and divider counts of the reload timer
package drt_pkg;
    // --------------------------------------------------------------------
    // Register byte offsets
    // --------------------------------------------------------------------
    localparam logic [7:0] DRT_OFF_CTRL = 8'h00;
    localparam logic [7:0] DRT_OFF_CLKSEL = 8'h04;
    localparam logic [7:0] DRT_OFF_CNT_LO = 8'h08;
    localparam logic [7:0] DRT_OFF_CNT_HI = 8'h0c;
    localparam logic [7:0] DRT_OFF_RLD_LO = 8'h10;
    localparam logic [7:0] DRT_OFF_RLD_HI = 8'h14;
    localparam logic [7:0] DRT_OFF_IRQ_EN = 8'h18;
    localparam logic [7:0] DRT_OFF_STATUS = 8'h1c;
    localparam logic [7:0] DRT_OFF_MASK = 8'h20;

    // --------------------------------------------------------------------
    // Control register bit positions
    // --------------------------------------------------------------------
    localparam int DRT_B_HFLAG = 7;
    localparam int DRT_B_LFLAG = 6;
    localparam int DRT_B_LEN = 5;
    localparam int DRT_B_CAPEN = 4;
    localparam int DRT_B_SPLIT = 3;
    localparam int DRT_B_RUN = 2;
    localparam int DRT_B_XCLK = 0;

    // Clock select register bit positions
    localparam int DRT_B_LSEL = 0;
    localparam int DRT_B_HSEL = 1;

    // Timer interrupt enable bit position
    localparam int DRT_B_TIE = 0;

    // Status and mask bit positions
    localparam int DRT_S_HOVF = 0;
    localparam int DRT_S_LOVF = 1;
    localparam int DRT_S_CAP = 2;
    localparam int DRT_NSTAT = 3;

    // --------------------------------------------------------------------
    // Reset values
    // --------------------------------------------------------------------
    localparam logic [7:0] DRT_RST_CTRL = 8'h00;
    localparam logic [1:0] DRT_RST_CLKSEL = 2'h0;
    localparam logic [7:0] DRT_RST_BYTE = 8'h00;
    localparam logic [2:0] DRT_RST_STAT = 3'h0;

    // --------------------------------------------------------------------
    // Timing counts
    // --------------------------------------------------------------------
    localparam int DRT_CORE_DIV = 12;
    localparam int DRT_EXT_DIV = 8;
    localparam logic [7:0] DRT_BYTE_MAX = 8'hff;
endpackage

// File: include/drt_tick_if.sv
// Interface: clock select inputs and counting ticks between control and tick generator
`timescale 1ns/100ps
`default_nettype none
interface drt_tick_if;
    logic high_clock_select;
    logic low_clock_select;
    logic ext_clock_select;
    logic tick_hi;
    logic tick_lo;

    modport ctrl (output high_clock_select, output low_clock_select, output ext_clock_select,
                  input tick_hi, input tick_lo);
    modport gen (input high_clock_select, input low_clock_select, input ext_clock_select,
                 output tick_hi, output tick_lo);
endinterface
`default_nettype wire

// File: rtl/drt_byte_cnt.sv
// Byte counter: increments on enable, reloads on wrap or forced reload, software load
`timescale 1ns/100ps
`default_nettype none
module drt_byte_cnt
    import drt_pkg::*;
#(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Counting control
    input wire logic inc,
    input wire logic reload_on_wrap,
    input wire logic force_reload,
    input wire logic [WIDTH-1:0] reload_val,
    // Software load
    input wire logic sw_load,
    input wire logic [WIDTH-1:0] sw_val,
    // State
    output logic [WIDTH-1:0] count,
    output logic wrap
);
    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    logic [WIDTH-1:0] cnt_r;
    logic [WIDTH-1:0] cnt_nxt;

    assign count = cnt_r;
    assign wrap = inc & (&cnt_r);
    // Software write wins over counting
    assign cnt_nxt = sw_load ? sw_val :
                     (force_reload | (wrap & reload_on_wrap)) ? reload_val :
                     inc ? cnt_r + {{(WIDTH-1){1'b0}}, 1'b1} : cnt_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule
`default_nettype wire

// File: rtl/drt_tick_gen.sv
// Tick generator: core clock, core clock / 12, and synchronised external oscillator / 8
`timescale 1ns/100ps
`default_nettype none
module drt_tick_gen
    import drt_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // External oscillator
    input wire logic ext_osc_i,
    // Tick carrier
    drt_tick_if.gen tk
);
    // ------------------------------------------------------------------
    // Dividers
    // ------------------------------------------------------------------
    logic [3:0] div12_r;
    logic ext_s1_r;
    logic ext_s2_r;
    logic ext_prev_r;
    logic [2:0] ext_cnt_r;
    logic tick_div12;
    logic ext_edge;
    logic tick_ext;
    logic tick_slow;

    assign tick_div12 = (div12_r == 4'(DRT_CORE_DIV - 1));
    assign ext_edge = ext_s2_r & ~ext_prev_r;
    assign tick_ext = ext_edge & (ext_cnt_r == 3'(DRT_EXT_DIV - 1));
    assign tick_slow = tk.ext_clock_select ? tick_ext : tick_div12;
    // Per-byte source choice
    assign tk.tick_hi = tk.high_clock_select ? 1'b1 : tick_slow;
    assign tk.tick_lo = tk.low_clock_select ? 1'b1 : tick_slow;

    // Core clock divided by 12
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div12_r <= 4'h0;
        end else begin
            div12_r <= tick_div12 ? 4'h0 : div12_r + 4'h1;
        end
    end

    // Two-stage sync, then count rising edges by 8
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_prev_r <= 1'b0;
            ext_cnt_r <= 3'h0;
        end else begin
            ext_s1_r <= ext_osc_i;
            ext_s2_r <= ext_s1_r;
            ext_prev_r <= ext_s2_r;
            if (ext_edge) begin
                ext_cnt_r <= ext_cnt_r + 3'h1;
            end
        end
    end
endmodule
`default_nettype wire

// File: rtl/drt_timer.sv
// Dual mode reload timer: APB registers, 16-bit or split 8-bit counting, flags, interrupt
`timescale 1ns/100ps
`default_nettype none
module drt_timer
    import drt_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Clock sources
    input wire logic ext_osc_i,
    input wire logic lf_osc_i,
    // Interrupt
    output logic irq_o
);
    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic [1:0] clksel_r;
    logic tie_r;
    logic [7:0] rld_lo_r;
    logic [7:0] rld_hi_r;
    logic [DRT_NSTAT-1:0] stat_r;
    logic [DRT_NSTAT-1:0] stat_nxt;
    logic [DRT_NSTAT-1:0] mask_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic irq_r;
    logic lf_prev_r;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    logic setup;
    logic done;
    logic wr;
    logic rd;
    logic hit_ctrl;
    logic hit_clksel;
    logic hit_cnt_lo;
    logic hit_cnt_hi;
    logic hit_rld_lo;
    logic hit_rld_hi;
    logic hit_irq_en;
    logic hit_status;
    logic hit_mask;
    logic mapped;
    logic [31:0] rd_mux;

    assign setup = psel & ~penable;
    assign done = psel & penable & pready_r;
    assign wr = done & pwrite;
    assign rd = done & ~pwrite;
    assign hit_ctrl = (paddr == DRT_OFF_CTRL);
    assign hit_clksel = (paddr == DRT_OFF_CLKSEL);
    assign hit_cnt_lo = (paddr == DRT_OFF_CNT_LO);
    assign hit_cnt_hi = (paddr == DRT_OFF_CNT_HI);
    assign hit_rld_lo = (paddr == DRT_OFF_RLD_LO);
    assign hit_rld_hi = (paddr == DRT_OFF_RLD_HI);
    assign hit_irq_en = (paddr == DRT_OFF_IRQ_EN);
    assign hit_status = (paddr == DRT_OFF_STATUS);
    assign hit_mask = (paddr == DRT_OFF_MASK);
    assign mapped = hit_ctrl | hit_clksel | hit_cnt_lo | hit_cnt_hi | hit_rld_lo | hit_rld_hi
                  | hit_irq_en | hit_status | hit_mask;

    // ------------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------------
    logic split;
    logic run;
    logic len;
    logic capen;

    assign split = ctrl_r[DRT_B_SPLIT];
    assign run = ctrl_r[DRT_B_RUN];
    assign len = ctrl_r[DRT_B_LEN];
    assign capen = ctrl_r[DRT_B_CAPEN];

    // ------------------------------------------------------------------
    // Tick generator
    // ------------------------------------------------------------------
    drt_tick_if tk ();

    assign tk.high_clock_select = clksel_r[DRT_B_HSEL];
    assign tk.low_clock_select = clksel_r[DRT_B_LSEL];
    assign tk.ext_clock_select = ctrl_r[DRT_B_XCLK];

    drt_tick_gen u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .ext_osc_i(ext_osc_i),
        .tk(tk)
    );

    // ------------------------------------------------------------------
    // Byte counters
    // ------------------------------------------------------------------
    logic inc_lo;
    logic inc_hi;
    logic wrap_lo;
    logic wrap_hi;
    logic [7:0] cnt_lo;
    logic [7:0] cnt_hi;

    // Low byte free-runs in split mode, high byte gated by run
    assign inc_lo = split ? tk.tick_lo : (tk.tick_lo & run);
    assign inc_hi = split ? (tk.tick_hi & run) : wrap_lo;

    drt_byte_cnt #(.WIDTH(8)) u_lo (
        .pclk(pclk),
        .presetn(presetn),
        .inc(inc_lo),
        .reload_on_wrap(split),
        .force_reload(~split & wrap_hi),
        .reload_val(rld_lo_r),
        .sw_load(wr & hit_cnt_lo),
        .sw_val(pwdata[7:0]),
        .count(cnt_lo),
        .wrap(wrap_lo)
    );

    drt_byte_cnt #(.WIDTH(8)) u_hi (
        .pclk(pclk),
        .presetn(presetn),
        .inc(inc_hi),
        .reload_on_wrap(1'b1),
        .force_reload(1'b0),
        .reload_val(rld_hi_r),
        .sw_load(wr & hit_cnt_hi),
        .sw_val(pwdata[7:0]),
        .count(cnt_hi),
        .wrap(wrap_hi)
    );

    // ------------------------------------------------------------------
    // Events
    // ------------------------------------------------------------------
    logic lf_edge;
    logic cap;
    logic [DRT_NSTAT-1:0] ev;

    assign lf_edge = lf_osc_i ^ lf_prev_r;
    assign cap = capen & tie_r & lf_edge;
    assign ev[DRT_S_HOVF] = wrap_hi;
    assign ev[DRT_S_LOVF] = wrap_lo & len;
    assign ev[DRT_S_CAP] = cap;

    // Flags: hardware set wins over software write, never self-cleared
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr && hit_ctrl) begin
            ctrl_nxt = pwdata[7:0];
            ctrl_nxt[1] = 1'b0;
        end
        if (wrap_hi) begin
            ctrl_nxt[DRT_B_HFLAG] = 1'b1;
        end
        if (wrap_lo) begin
            ctrl_nxt[DRT_B_LFLAG] = 1'b1;
        end
    end

    // Sticky status: a read clears only the bits it returned, so a late event survives
    assign stat_nxt = ((rd && hit_status) ? (stat_r & ~prdata_r[DRT_NSTAT-1:0]) : stat_r) | ev;

    // Read data mux
    assign rd_mux = hit_ctrl ? {24'h0, ctrl_r} :
                    hit_clksel ? {30'h0, clksel_r} :
                    hit_cnt_lo ? {24'h0, cnt_lo} :
                    hit_cnt_hi ? {24'h0, cnt_hi} :
                    hit_rld_lo ? {24'h0, rld_lo_r} :
                    hit_rld_hi ? {24'h0, rld_hi_r} :
                    hit_irq_en ? {31'h0, tie_r} :
                    hit_status ? {29'h0, stat_r} :
                    hit_mask ? {29'h0, mask_r} : 32'h0;

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= DRT_RST_CTRL;
            clksel_r <= DRT_RST_CLKSEL;
            tie_r <= 1'b0;
            stat_r <= DRT_RST_STAT;
            mask_r <= DRT_RST_STAT;
            lf_prev_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            stat_r <= stat_nxt;
            lf_prev_r <= lf_osc_i;
            if (wr && hit_clksel) begin
                clksel_r <= pwdata[1:0];
            end
            if (wr && hit_irq_en) begin
                tie_r <= pwdata[DRT_B_TIE];
            end
            if (wr && hit_mask) begin
                mask_r <= pwdata[DRT_NSTAT-1:0];
            end
        end
    end

    // Reload bytes: capture copy wins over software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rld_lo_r <= DRT_RST_BYTE;
            rld_hi_r <= DRT_RST_BYTE;
        end else if (cap) begin
            rld_lo_r <= cnt_lo;
            rld_hi_r <= cnt_hi;
        end else begin
            if (wr && hit_rld_lo) begin
                rld_lo_r <= pwdata[7:0];
            end
            if (wr && hit_rld_hi) begin
                rld_hi_r <= pwdata[7:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // APB answer and interrupt output
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
            irq_r <= 1'b0;
        end else begin
            pready_r <= setup; // One wait-free access phase
            if (setup) begin
                pslverr_r <= ~mapped;
                prdata_r <= rd_mux;
            end
            irq_r <= tie_r & (|(stat_nxt & mask_r));
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign irq_o = irq_r;
endmodule
`default_nettype wire

// File: tb/drt_timer_checker.sv
// Checker: APB response and interrupt relations of the reload timer
`timescale 1ns/100ps
`default_nettype none
module drt_timer_checker (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Clock sources and interrupt
    input wire logic ext_osc_i,
    input wire logic lf_osc_i,
    input wire logic irq_o
);
    // ------------------------------------------------------------
    // Helper state
    // ------------------------------------------------------------
    logic tie_r;
    logic [2:0] mask_r;
    // Decode of the bus phases
    wire logic setup = psel && !penable;
    wire logic done = psel && penable && pready && pwrite;
    wire logic mapped = (paddr <= 8'h20) && (paddr[1:0] == 2'b00);

    // Shadow of interrupt enable and mask
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tie_r <= 1'b0;
            mask_r <= 3'h0;
        end else if (done && paddr == 8'h18) begin
            tie_r <= pwdata[0];
        end else if (done && paddr == 8'h20) begin
            mask_r <= pwdata[2:0];
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_ready_after_setup: assert property (setup |=> pready)
        else $error("pready missing in access cycle");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("pready held past access cycle");
    chk_err_unmapped: assert property (setup && !mapped |=> pslverr)
        else $error("no error for unmapped address");
    chk_ok_mapped: assert property (setup && mapped |=> !pslverr)
        else $error("error for mapped address");
    chk_err_reads_zero: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("refused read returned data");
    chk_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    chk_irq_needs_enable: assert property (!tie_r && !$past(tie_r) |-> !irq_o)
        else $error("interrupt with timer interrupt disabled");
    chk_irq_needs_mask: assert property (mask_r == 3'h0 && $past(mask_r) == 3'h0 |-> !irq_o)
        else $error("interrupt with all sources masked");
    chk_reset_quiet: assert property ($rose(presetn) |-> !irq_o && !pready && !pslverr)
        else $error("output active right after reset");

    cov_refused: cover property (setup && !mapped);
    cov_write: cover property (done);
    cov_irq: cover property ($rose(irq_o));
    cov_lf_edge: cover property ($changed(lf_osc_i));
    cov_ext_pulse: cover property ($rose(ext_osc_i));
endmodule

bind drt_timer drt_timer_checker i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_osc_i(ext_osc_i), .lf_osc_i(lf_osc_i), .irq_o(irq_o));
`default_nettype wire

// File: tb/dual_mode_reload_timer_test.sv
// Testbench: register level tests of the dual mode reload timer
`timescale 1ns/100ps
`default_nettype none
module dual_mode_reload_timer_test
    import drt_pkg::*;
;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic pclk, presetn, psel, penable, pwrite, ext_osc_i, lf_osc_i, last_err;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, irq_o;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;

    drt_timer i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ext_osc_i(ext_osc_i), .lf_osc_i(lf_osc_i), .irq_o(irq_o));

    // Clock at 40 MHz
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic print_verdict;
        $display("comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", nm, exp, got);
        end
    endtask

    task automatic chk1(input string nm, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %b, seen %b", nm, exp, got);
        end
    endtask

    // One APB transfer, waiting for pready; the run bound catches a hang
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(a, 1'b1, d, q);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        logic [31:0] q;
        apb(a, 1'b0, 32'h0, q);
        chk(nm, exp, q);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask

    // Slow external oscillator pulses, then time for synchronisation
    task automatic ext_edges(input int n);
        repeat (n) begin
            @(posedge pclk);
            ext_osc_i <= 1'b1;
            idle(4);
            ext_osc_i <= 1'b0;
            idle(3);
        end
        idle(8);
    endtask

    // Bound on the run length
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            err_total++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, ext_osc_i, lf_osc_i, last_err} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        presetn = 1'b0;
        idle(20);
        presetn <= 1'b1;
        idle(2);
        // Reset values, unused bit and refused address
        for (int i = 0; i <= 8; i++) rd(8'(i * 4), 32'h0, "reset value");
        rd(8'h24, 32'h0, "unmapped read");
        chk1("unmapped error", 1'b1, last_err);
        wr(DRT_OFF_CTRL, 32'h02);
        rd(DRT_OFF_CTRL, 32'h0, "ctrl unused bit");
        // 16-bit wrap on core clock, stopped counter holds
        wr(DRT_OFF_CLKSEL, 32'h1);
        wr(DRT_OFF_CNT_LO, 32'hff);
        wr(DRT_OFF_CNT_HI, 32'hff);
        wr(DRT_OFF_RLD_HI, 32'h12);
        wr(DRT_OFF_IRQ_EN, 32'h1);
        wr(DRT_OFF_MASK, 32'h7);
        idle(20);
        rd(DRT_OFF_CNT_LO, 32'hff, "stopped count");
        wr(DRT_OFF_CTRL, 32'h24);
        wr(DRT_OFF_CTRL, 32'he0);
        chk1("irq 16-bit", 1'b1, irq_o);
        rd(DRT_OFF_CNT_HI, 32'h12, "reloaded high");
        rd(DRT_OFF_CTRL, 32'he0, "flags 16-bit");
        rd(DRT_OFF_STATUS, 32'h3, "status 16-bit");
        idle(2);
        chk1("irq after clear", 1'b0, irq_o);
        rd(DRT_OFF_CTRL, 32'he0, "flags kept");
        wr(DRT_OFF_CTRL, 32'h20);
        rd(DRT_OFF_CTRL, 32'h20, "flags cleared");
        // Masked event sets status but no interrupt
        wr(DRT_OFF_MASK, 32'h0);
        wr(DRT_OFF_CNT_LO, 32'hff);
        wr(DRT_OFF_CNT_HI, 32'hff);
        wr(DRT_OFF_CTRL, 32'h04);
        wr(DRT_OFF_CTRL, 32'h00);
        idle(3);
        chk1("irq masked", 1'b0, irq_o);
        rd(DRT_OFF_STATUS, 32'h1, "status masked");
        wr(DRT_OFF_MASK, 32'h7);
        // Capture on a low-frequency oscillator edge
        wr(DRT_OFF_CNT_LO, 32'h78);
        wr(DRT_OFF_CNT_HI, 32'h56);
        wr(DRT_OFF_CTRL, 32'h10);
        lf_osc_i <= 1'b1;
        idle(3);
        rd(DRT_OFF_RLD_LO, 32'h78, "captured low");
        rd(DRT_OFF_RLD_HI, 32'h56, "captured high");
        rd(DRT_OFF_STATUS, 32'h4, "status capture");
        // Split mode, both bytes on external clock / 8
        wr(DRT_OFF_CTRL, 32'h00);
        wr(DRT_OFF_CLKSEL, 32'h0);
        wr(DRT_OFF_RLD_HI, 32'h34);
        wr(DRT_OFF_CNT_HI, 32'hff);
        wr(DRT_OFF_CNT_LO, 32'h00);
        wr(DRT_OFF_CTRL, 32'h09);
        ext_edges(8);
        rd(DRT_OFF_CNT_LO, 32'h01, "low on ext clock");
        rd(DRT_OFF_CNT_HI, 32'hff, "high gated");
        wr(DRT_OFF_CTRL, 32'h0d);
        ext_edges(7);
        rd(DRT_OFF_CTRL, 32'h0d, "no early tick");
        chk1("irq before wrap", 1'b0, irq_o);
        ext_edges(1);
        chk1("irq high wrap", 1'b1, irq_o);
        rd(DRT_OFF_CTRL, 32'h8d, "high flag split");
        rd(DRT_OFF_CNT_HI, 32'h34, "high reload byte");
        rd(DRT_OFF_CNT_LO, 32'h02, "low ext count");
        rd(DRT_OFF_STATUS, 32'h1, "status high");
        // Low byte on core clock wraps, interrupt only with low enable
        wr(DRT_OFF_RLD_LO, 32'hf0);
        wr(DRT_OFF_CNT_LO, 32'hf0);
        wr(DRT_OFF_CLKSEL, 32'h1);
        idle(40);
        rd(DRT_OFF_CTRL, 32'hcd, "low flag split");
        chk1("irq low disabled", 1'b0, irq_o);
        rd(DRT_OFF_STATUS, 32'h0, "status low off");
        wr(DRT_OFF_CTRL, 32'h2d);
        idle(40);
        chk1("irq low enabled", 1'b1, irq_o);
        rd(DRT_OFF_STATUS, 32'h2, "status low source");
        rd(DRT_OFF_CTRL, 32'h6d, "only low flag");
        // High byte on core clock
        wr(DRT_OFF_CNT_HI, 32'hff);
        wr(DRT_OFF_CLKSEL, 32'h3);
        idle(4);
        rd(DRT_OFF_CTRL, 32'hed, "high on core clock");
        print_verdict();
    end
endmodule
`default_nettype wire
